// file: rtl/aom_combine.sv
`timescale 1ns/1ps
module aom_combine (
	// Configuration
	input  wire aom_pkg::matrix_cfg_t cfg_i,
	// Drive status flags
	input  wire logic [7:0]           status_i,
	// Result
	output logic                      out_active_o
);
	logic [7:0] term;
	logic       combined;

	assign term = status_i ^ cfg_i.invert_bits;
	assign combined = |(term & cfg_i.assign_bits);
	assign out_active_o = combined ^ cfg_i.select_nc;
endmodule // aom_combine

// file: rtl/aom_pkg.sv
package aom_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_ASSIGN    = 8'h00;
	localparam logic [7:0] OFF_INVERT    = 8'h04;
	localparam logic [7:0] OFF_SELECT    = 8'h08;
	localparam logic [7:0] OFF_STATUS    = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
	localparam logic [7:0] OFF_SERIAL    = 8'h18;

	// Field positions
	localparam int POS_STALL       = 0;
	localparam int POS_LOWER_ALARM = 4;
	localparam int POS_UPPER_ALARM = 5;
	localparam int POS_SELECT_NC   = 0;
	localparam int POS_IRQ_OUT     = 0;
	localparam int POS_IRQ_CHANGE  = 1;

	// Reset values
	localparam logic [7:0] RST_ASSIGN   = 8'h00;
	localparam logic [7:0] RST_INVERT   = 8'h00;
	localparam logic       RST_SELECT   = 1'b0;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;

	// Factory serial framing
	localparam int         SERIAL_BAUD      = 300;
	localparam logic [3:0] SERIAL_DATA_BITS = 4'h8;
	localparam logic [1:0] SERIAL_STOP_BITS = 2'h1;
	localparam logic [2:0] SERIAL_BAUD_CODE = 3'h1;

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] assign_bits;
		logic [7:0] invert_bits;
		logic       select_nc;
	} matrix_cfg_t;

endpackage

// file: rtl/assignable_output_matrix.sv
`timescale 1ns/1ps
// Summary of operation
// - Assignment bit weight 1 routes pickup-stalled to the output.
// - Weights 32 and 16 route upper and lower limit alarms, ORed.
// - An inversion value of zero leaves every condition uninverted.
// - Selector zero gives normally-open: off unless combined is active.
// - Assignment and inversion each hold eight switches, switch n at weight 2^(n-1).
// - The stored value is the sum of the on switches, read back as is.
// - Factory serial framing is 300 baud, eight data, one stop bit.
// - Each inversion bit complements its own condition independently.
// - Selector picks normally-open or normally-closed final sense.
// - The eight conditions are the drive status flags bit for bit.
module assignable_output_matrix (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Drive status flags
	input  wire logic [7:0]  drive_status_i,
	// Write address channel
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	// Write data channel
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// Write response channel
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// Read address channel
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	// Read data channel
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Open-collector output and interrupt
	output logic             out_drive_o,
	output logic             irq_o
);
	aom_pkg::matrix_cfg_t cfg;
	logic [7:0]  status_s1;
	logic [7:0]  status_s2;
	logic        out_active;
	logic        out_prev;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	logic [1:0]  irq_event;
	logic [1:0]  irq_clear;
	logic [1:0]  next_irq_stat;

	// Write path state
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        wr_hit;
	logic        wr_assign;
	logic        wr_invert;
	logic        wr_select;
	logic        wr_irq_stat;
	logic        wr_irq_mask;
	logic        wr_lane0;
	logic [7:0]  next_assign;
	logic [7:0]  next_invert;

	// Handshake decode
	logic        aw_take;
	logic        w_take;
	logic        b_done;
	logic        next_awready;
	logic        next_wready;

	// Read path
	logic        rd_fire;
	logic        rd_hit;
	logic [31:0] rd_word;
	logic        r_done;
	logic        next_arready;

	// Mapped offsets; a miss answers SLVERR on either path
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == aom_pkg::OFF_ASSIGN)
			|| (a == aom_pkg::OFF_INVERT)
			|| (a == aom_pkg::OFF_SELECT)
			|| (a == aom_pkg::OFF_STATUS)
			|| (a == aom_pkg::OFF_IRQ_STAT)
			|| (a == aom_pkg::OFF_IRQ_MASK)
			|| (a == aom_pkg::OFF_SERIAL);
	endfunction

	// Flags arrive from outside the clock domain
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			status_s1 <= 8'h00;
			status_s2 <= 8'h00;
		end else begin
			status_s1 <= drive_status_i;
			status_s2 <= status_s1;
		end
	end

	aom_combine u_combine (
		.cfg_i        (cfg),
		.status_i     (status_s2),
		.out_active_o (out_active)
	);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			out_drive_o <= 1'b0;
			out_prev    <= 1'b0;
		end else begin
			out_drive_o <= out_active;
			out_prev    <= out_drive_o;
		end
	end

	// Write channel capture, address and data in either order
	// A held pair waits until the last response is taken
	assign wr_fire  = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_hit   = addr_known(aw_addr);
	// Lane 0 carries every writable register
	assign wr_lane0 = w_strb[0];
	assign wr_assign   = wr_fire && wr_lane0
		&& (aw_addr == aom_pkg::OFF_ASSIGN);
	assign wr_invert   = wr_fire && wr_lane0
		&& (aw_addr == aom_pkg::OFF_INVERT);
	assign wr_select   = wr_fire && wr_lane0
		&& (aw_addr == aom_pkg::OFF_SELECT);
	assign wr_irq_stat = wr_fire && wr_lane0
		&& (aw_addr == aom_pkg::OFF_IRQ_STAT);
	assign wr_irq_mask = wr_fire && wr_lane0
		&& (aw_addr == aom_pkg::OFF_IRQ_MASK);

	assign next_assign = w_data[7:0];
	assign next_invert = w_data[7:0];

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (aw_take) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (w_take) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// Slot fills at the take; ready returns once the slot drains
	assign aw_take      = s_axi_awvalid_i && s_axi_awready_o;
	assign w_take       = s_axi_wvalid_i && s_axi_wready_o;
	assign b_done       = s_axi_bvalid_o && s_axi_bready_i;
	assign next_awready = !aw_held && !aw_take;
	assign next_wready  = !w_held && !w_take;

	// Ready only while the holding slot is empty
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
		end else begin
			s_axi_awready_o <= next_awready;
			s_axi_wready_o  <= next_wready;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= aom_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_hit ? aom_pkg::RESP_OKAY
				: aom_pkg::RESP_SLVERR;
		end else if (b_done) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cfg.assign_bits <= aom_pkg::RST_ASSIGN;
			cfg.invert_bits <= aom_pkg::RST_INVERT;
			cfg.select_nc   <= aom_pkg::RST_SELECT;
		end else begin
			if (wr_assign)
				cfg.assign_bits <= next_assign;
			if (wr_invert)
				cfg.invert_bits <= next_invert;
			if (wr_select)
				cfg.select_nc <= w_data[aom_pkg::POS_SELECT_NC];
		end
	end

	// Events: output switched on, output changed
	assign irq_event[aom_pkg::POS_IRQ_OUT]    = out_drive_o && !out_prev;
	assign irq_event[aom_pkg::POS_IRQ_CHANGE] = out_drive_o ^ out_prev;
	assign irq_clear = wr_irq_stat ? w_data[1:0] : 2'h0;
	// Set wins over a clear in the same cycle
	assign next_irq_stat = (irq_stat & ~irq_clear) | irq_event;

	// Sticky status; the level output updates on the same clock as the status
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat <= 2'h0;
			irq_mask <= aom_pkg::RST_IRQ_MASK;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_irq_mask)
				irq_mask <= w_data[1:0];
			irq_o <= |(next_irq_stat & irq_mask);
		end
	end

	// Read path
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
	assign rd_hit  = addr_known(s_axi_araddr_i);
	assign r_done  = s_axi_rvalid_o && s_axi_rready_i;

	// One read at a time: no new address while an answer stands
	assign next_arready = !rd_fire && (!s_axi_rvalid_o || s_axi_rready_i);

	// Live address decode; sampled only in the take cycle
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr_i)
			aom_pkg::OFF_ASSIGN:   rd_word[7:0] = cfg.assign_bits;
			aom_pkg::OFF_INVERT:   rd_word[7:0] = cfg.invert_bits;
			aom_pkg::OFF_SELECT:   rd_word[0]   = cfg.select_nc;
			aom_pkg::OFF_STATUS: begin
				rd_word[7:0] = status_s2;
				rd_word[8]   = out_drive_o;
			end
			aom_pkg::OFF_IRQ_STAT: rd_word[1:0] = irq_stat;
			aom_pkg::OFF_IRQ_MASK: rd_word[1:0] = irq_mask;
			aom_pkg::OFF_SERIAL: begin
				rd_word[2:0] = aom_pkg::SERIAL_BAUD_CODE;
				rd_word[7:4] = aom_pkg::SERIAL_DATA_BITS;
				rd_word[9:8] = aom_pkg::SERIAL_STOP_BITS;
			end
			default:               rd_word = 32'h0000_0000;
		endcase
	end

	// Address taken only while no answer stands
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			s_axi_arready_o <= 1'b0;
		else
			s_axi_arready_o <= next_arready;
	end

	// Answer stands until the master takes it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= aom_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_word;
			s_axi_rresp_o   <= rd_hit ? aom_pkg::RESP_OKAY
				: aom_pkg::RESP_SLVERR;
		end else if (r_done) begin
			s_axi_rvalid_o  <= 1'b0;
		end
	end
endmodule // assignable_output_matrix

// file: verif/aom_load_model.sv
`timescale 1ns/1ps
module aom_load_model (
	input  wire logic drive_i,
	output logic      lamp_on_o
);
	// Sinking transistor lights the load
	assign lamp_on_o = drive_i;
endmodule // aom_load_model

// file: verif/assignable_output_matrix_assertions.sv
`timescale 1ns/1ps
module aom_checker (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic [7:0]  drive_status_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        out_drive_o
);
	logic [7:0] ra;
	logic [7:0] st_q;
	logic [2:0] quiet;
	// Flags and config both still: output must hold
	wire logic calm = drive_status_i == st_q && !s_axi_bvalid_o
		&& !s_axi_awvalid_i;
	wire logic [2:0] next_quiet = !calm ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ra <= 8'h00;
			st_q <= 8'h00;
			quiet <= 3'h0;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o)
				ra <= s_axi_araddr_i;
			st_q <= drive_status_i;
			quiet <= next_quiet;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=>
			s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=>
			s_axi_rvalid_o && $stable(s_axi_rdata_o)
			&& $stable(s_axi_rresp_o);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read answer dropped");
	property p_ar_block;
		s_axi_rvalid_o |-> !s_axi_arready_o;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read address taken while busy");
	property p_b_time;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
			&& s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o;
	endproperty
	a_b_time: assert property (p_b_time)
		else $error("write response late");
	property p_r_time;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_r_time: assert property (p_r_time)
		else $error("read data late");
	property p_serial;
		s_axi_rvalid_o && ra == aom_pkg::OFF_SERIAL |->
			s_axi_rdata_o[9:0] == 10'h181;
	endproperty
	a_serial: assert property (p_serial)
		else $error("serial framing wrong");
	property p_unmapped;
		s_axi_rvalid_o && ra > 8'h18 |-> s_axi_rdata_o == 32'h0
			&& s_axi_rresp_o == aom_pkg::RESP_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read answered");
	property p_mapped;
		s_axi_rvalid_o && ra <= 8'h18 && ra[1:0] == 2'h0 |->
			s_axi_rresp_o == aom_pkg::RESP_OKAY;
	endproperty
	a_mapped: assert property (p_mapped)
		else $error("mapped read refused");
	property p_quiet;
		quiet >= 3'h4 |-> $stable(out_drive_o);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("output moved without cause");
	c_serial: cover property (s_axi_rvalid_o && ra == aom_pkg::OFF_SERIAL);
	c_on: cover property ($rose(out_drive_o));
	c_bad: cover property (s_axi_rvalid_o && ra > 8'h18);
endmodule // aom_checker
bind assignable_output_matrix aom_checker u_chk (.clk_sys_i, .rst_i,
	.drive_status_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .out_drive_o);

// file: verif/assignable_output_matrix_tb.sv
`timescale 1ns/1ps
module assignable_output_matrix_tb;
	logic        clk_sys_i, rst_i, lamp, out_drive_o, irq_o;
	logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_bvalid_o;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_arready_o;
	logic        s_axi_rvalid_o;
	logic [7:0]  drive_status_i, s_axi_awaddr_i, s_axi_araddr_i;
	logic [3:0]  s_axi_wstrb_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	int          n_fail, n_compared;
	assignable_output_matrix u_dut (.clk_sys_i, .rst_i, .drive_status_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .out_drive_o, .irq_o);
	aom_load_model u_load (.drive_i(out_drive_o), .lamp_on_o(lamp));
	task automatic end_sim;
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ao, wo, bd;
		{ao, wo, bd} = 3'b110;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
		while (!bd) begin
			@(posedge clk_sys_i);
			if (ao && s_axi_awready_o) begin
				ao = 1'b0;
				s_axi_awvalid_i <= 1'b0;
			end
			if (wo && s_axi_wready_o) begin
				wo = 1'b0;
				s_axi_wvalid_i <= 1'b0;
			end
			if (s_axi_bvalid_o) begin
				bd = 1'b1;
				chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
			end
		end
		s_axi_bready_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ao, dn;
		{ao, dn} = 2'b10;
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
		while (!dn) begin
			@(posedge clk_sys_i);
			if (ao && s_axi_arready_o) begin
				ao = 1'b0;
				s_axi_arvalid_i <= 1'b0;
			end
			if (s_axi_rvalid_o) begin
				dn = 1'b1;
				chk($sformatf("rdata@%h", a), e, s_axi_rdata_o);
				chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
			end
		end
		s_axi_rready_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	// Expected output worked out as OR of assigned flag xor invert, then xor selector
	task automatic scen(input logic [7:0] as, iv, input logic sel,
		input logic [7:0] st);
		wr(aom_pkg::OFF_ASSIGN, {24'h0, as}, aom_pkg::RESP_OKAY);
		wr(aom_pkg::OFF_INVERT, {24'h0, iv}, aom_pkg::RESP_OKAY);
		wr(aom_pkg::OFF_SELECT, {31'h0, sel}, aom_pkg::RESP_OKAY);
		drive_status_i <= st;
		repeat (6) @(posedge clk_sys_i);
		chk("lamp", {31'h0, (|(as & (st ^ iv))) ^ sel}, {31'h0, lamp});
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#100us;
		n_fail++;
		end_sim();
	end
	initial begin
		{n_fail, n_compared} = '0;
		{rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h8;
		{s_axi_arvalid_i, s_axi_rready_i} = 2'b00;
		{drive_status_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
		s_axi_wdata_i = 32'h0;
		s_axi_wstrb_i = 4'hf;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd(aom_pkg::OFF_ASSIGN, 32'h0, 2'h0);
		rd(aom_pkg::OFF_INVERT, 32'h0, 2'h0);
		rd(aom_pkg::OFF_SELECT, 32'h0, 2'h0);
		rd(aom_pkg::OFF_IRQ_MASK, 32'h0, 2'h0);
		rd(aom_pkg::OFF_SERIAL, 32'h181, 2'h0);
		rd(8'h40, 32'h0, aom_pkg::RESP_SLVERR);
		wr(8'h40, 32'hff, aom_pkg::RESP_SLVERR);
		scen(8'h01, 8'h00, 1'b0, 8'h01);
		scen(8'h01, 8'h00, 1'b0, 8'h00);
		scen(8'h30, 8'h00, 1'b0, 8'h10);
		scen(8'h30, 8'h00, 1'b0, 8'h20);
		scen(8'h30, 8'h00, 1'b0, 8'hcf);
		for (int i = 0; i < 8; i++) begin
			scen(8'h1 << i, 8'h1 << i, 1'b0, 8'h00);
			scen(8'h1 << i, 8'h1 << i, 1'b0, 8'h1 << i);
		end
		scen(8'h01, 8'h00, 1'b1, 8'h01);
		scen(8'h01, 8'h00, 1'b1, 8'h00);
		scen(8'h49, 8'h00, 1'b0, 8'h5a);
		rd(aom_pkg::OFF_ASSIGN, 32'h49, 2'h0);
		rd(aom_pkg::OFF_STATUS, 32'h15a, 2'h0);
		wr(aom_pkg::OFF_IRQ_MASK, 32'h1, 2'h0);
		repeat (2) @(posedge clk_sys_i);
		chk("irq", 32'h1, {31'h0, irq_o});
		wr(aom_pkg::OFF_IRQ_STAT, 32'h3, 2'h0);
		rd(aom_pkg::OFF_IRQ_STAT, 32'h0, 2'h0);
		chk("irq", 32'h0, {31'h0, irq_o});
		end_sim();
	end
endmodule // assignable_output_matrix_tb
